// >>> avmm_reg_slave.sv
module avmm_reg_slave
	import lic_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// avalon-mm slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// register
	output logic [7:0] o_ctrl
);
	logic [7:0] ctrl_ff, nxt_ctrl;
	logic [31:0] rdata_ff, nxt_rdata;
	logic ack_ff, nxt_ack;
	logic hit;

	// one wait cycle; answer at second edge of the request
	always_comb begin
		hit = (i_address == LIC_OFFSET);
		nxt_ack = (i_read | i_write) & ~ack_ff;
		nxt_ctrl = ctrl_ff;
		nxt_rdata = rdata_ff;
		if (nxt_ack && i_write && hit && i_byteenable[0]) begin
			nxt_ctrl = i_writedata[7:0] & LIC_WMASK;
		end
		if (nxt_ack && i_read) begin
			// unmapped reads return zero
			nxt_rdata = hit ? {24'h000000, ctrl_ff} : 32'h00000000;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ctrl_ff <= LIC_RESET;
			rdata_ff <= 32'h00000000;
			ack_ff <= 1'b0;
		end else if (i_clk_en) begin
			ctrl_ff <= nxt_ctrl;
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
		end
	end

	assign o_ctrl = ctrl_ff;
	assign o_readdata = rdata_ff;
	assign o_waitrequest = ~ack_ff;
endmodule // avmm_reg_slave

// >>> lic_pkg.sv
package lic_pkg;
	// register map: one 8-bit register in the low bits of an aligned word
	localparam logic [7:0] LIC_OFFSET = 8'h10;
	localparam logic [7:0] LIC_RESET = 8'h08;
	localparam logic [7:0] LIC_WMASK = 8'hef; // bit 4 reserved
	localparam int BIT_TERM_OFF_SQUELCH = 7;
	localparam int BIT_ONHOOK_SPEED = 6;
	localparam int BIT_AC_TERM = 5;
	localparam int DC_MODE_HI = 3;
	localparam int DC_MODE_LO = 2;
	localparam int BIT_RINGER_IMP = 1;
	localparam int BIT_RING_THR = 0;
	// on-hook durations in sample periods
	localparam int FAST_ONHOOK_TICKS = 1024;
	localparam int SLOW_ONHOOK_TICKS = 4096;
	localparam int ONHOOK_CNT_W = 13;

	// dc termination mode encodings
	typedef enum logic [1:0] {
		DC_LOW_VOLTAGE = 2'h0,
		DC_LOWER_VOLTAGE = 2'h1,
		DC_STANDARD = 2'h2,
		DC_CURRENT_LIMIT = 2'h3
	} dc_mode_e;

	// decoded line-interface controls
	typedef struct packed {
		logic dc_term_off;
		logic ring_squelch;
		logic ac_complex;
		dc_mode_e dc_mode;
		logic ringer_synth;
		logic ring_thr_high;
	} line_ctrl_s;
endpackage

// >>> line_interface_control.sv
// Summary of operation
// - register resets to 0x08, standard termination
// - off-hook bit 7 disables dc termination
// - on-hook bit 7 enables ring squelch
// - on-hook lasts 1024 or 4096 samples
// - bit 5 selects real or complex ac
// - bits 3:2 select dc termination mode
// - bit 1 selects high or synthesized ringer
// - bit 0 selects ring detect band
//
// Design decision made here: register access over Avalon-MM.
module line_interface_control
	import lic_pkg::*;
#(
	parameter int FAST_TICKS = FAST_ONHOOK_TICKS,
	parameter int SLOW_TICKS = SLOW_ONHOOK_TICKS
)(
	// clock, reset, enable
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	// avalon-mm slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// line state
	input wire logic i_offhook_req,
	input wire logic i_sample_tick,
	output logic o_offhook,
	output logic o_onhook_busy,
	// decoded controls to the analog side
	output line_ctrl_s o_line_ctrl
);
	logic [7:0] ctrl;
	logic tmr_busy, tmr_done;
	logic offhook_ff, nxt_offhook;
	line_ctrl_s lc_ff, nxt_lc;

	avmm_reg_slave i_avmm_reg_slave (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_address(i_address),
		.i_read(i_read),
		.i_write(i_write),
		.i_byteenable(i_byteenable),
		.i_writedata(i_writedata),
		.o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest),
		.o_ctrl(ctrl)
	);

	onhook_timer #(
		.FAST_TICKS(FAST_TICKS),
		.SLOW_TICKS(SLOW_TICKS)
	) i_onhook_timer (
		.i_ref_clk(i_ref_clk),
		.i_reset_n(i_reset_n),
		.i_clk_en(i_clk_en),
		.i_sample_tick(i_sample_tick),
		// done blocks a restart while the hook state is still falling
		.i_start(offhook_ff && !i_offhook_req && !tmr_done),
		.i_slow(ctrl[BIT_ONHOOK_SPEED]),
		.o_busy(tmr_busy),
		.o_done(tmr_done)
	);

	// line stays off-hook until the release counter runs out
	always_comb begin
		nxt_offhook = offhook_ff;
		if (!offhook_ff && i_offhook_req && !tmr_busy) begin
			nxt_offhook = 1'b1;
		end else if (tmr_done) begin
			nxt_offhook = 1'b0;
		end
		// bit 7 meaning follows hook state; squelch is gated off while off-hook
		nxt_lc.dc_term_off = nxt_offhook & ctrl[BIT_TERM_OFF_SQUELCH];
		nxt_lc.ring_squelch = ~nxt_offhook & ctrl[BIT_TERM_OFF_SQUELCH];
		nxt_lc.ac_complex = ctrl[BIT_AC_TERM];
		nxt_lc.dc_mode = dc_mode_e'(ctrl[DC_MODE_HI:DC_MODE_LO]);
		nxt_lc.ringer_synth = ctrl[BIT_RINGER_IMP];
		nxt_lc.ring_thr_high = ctrl[BIT_RING_THR];
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			offhook_ff <= 1'b0;
			lc_ff <= '{dc_term_off: 1'b0, ring_squelch: 1'b0,
				ac_complex: 1'b0, dc_mode: DC_STANDARD,
				ringer_synth: 1'b0, ring_thr_high: 1'b0};
		end else if (i_clk_en) begin
			offhook_ff <= nxt_offhook;
			lc_ff <= nxt_lc;
		end
	end

	assign o_offhook = offhook_ff;
	assign o_onhook_busy = tmr_busy;
	assign o_line_ctrl = lc_ff;

	// assertions
	AST_OFF_TERM: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_clk_en |=> lc_ff.dc_term_off == ($past(nxt_offhook)
		& $past(ctrl[BIT_TERM_OFF_SQUELCH])))
		else $error("dc term off mismatch");
	AST_SQUELCH: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		!(lc_ff.ring_squelch && offhook_ff))
		else $error("squelch while off-hook");
	AST_DC_MODE: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_clk_en |=> lc_ff.dc_mode == $past(ctrl[DC_MODE_HI:DC_MODE_LO]))
		else $error("dc mode mismatch");
	AST_AC_TERM: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_clk_en |=> lc_ff.ac_complex == $past(ctrl[BIT_AC_TERM]))
		else $error("ac term mismatch");
	AST_RINGER: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_clk_en |=> lc_ff.ringer_synth == $past(ctrl[BIT_RINGER_IMP]))
		else $error("ringer mismatch");
	AST_RING_THR: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
		i_clk_en |=> lc_ff.ring_thr_high == $past(ctrl[BIT_RING_THR]))
		else $error("ring threshold mismatch");
	AST_RESET_VAL: assert property (@(posedge i_ref_clk)
		$rose(i_reset_n) |-> ctrl == LIC_RESET)
		else $error("reset value wrong");
	AST_ONHOOK_HOLD: assert property (@(posedge i_ref_clk)
		disable iff (!i_reset_n)
		$rose(tmr_busy) |-> offhook_ff throughout tmr_busy [*8])
		else $error("released before counter");
	AST_DONE_CLEARS: assert property (@(posedge i_ref_clk)
		disable iff (!i_reset_n)
		(tmr_done && i_clk_en) |=> !offhook_ff)
		else $error("line not released");
endmodule // line_interface_control

// >>> onhook_timer.sv
module onhook_timer
	import lic_pkg::*;
#(
	parameter int FAST_TICKS = FAST_ONHOOK_TICKS,
	parameter int SLOW_TICKS = SLOW_ONHOOK_TICKS
)(
	input wire logic i_ref_clk,
	input wire logic i_reset_n,
	input wire logic i_clk_en,
	input wire logic i_sample_tick,
	input wire logic i_start,
	input wire logic i_slow,
	output logic o_busy,
	output logic o_done
);
	initial begin
		if (FAST_TICKS < 1 || SLOW_TICKS < 1 || FAST_TICKS >= 8192 ||
			SLOW_TICKS >= 8192) begin
			$error("onhook_timer: tick counts out of range");
		end
	end

	logic [ONHOOK_CNT_W-1:0] cnt_ff, nxt_cnt;
	logic busy_ff, nxt_busy, done_ff, nxt_done;

	// speed is latched on the start of the release
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		if (i_start && !busy_ff) begin
			nxt_busy = 1'b1;
			nxt_cnt = i_slow ? ONHOOK_CNT_W'(SLOW_TICKS)
				: ONHOOK_CNT_W'(FAST_TICKS);
		end else if (busy_ff && i_sample_tick) begin
			nxt_cnt = cnt_ff - 1'b1;
			if (cnt_ff == ONHOOK_CNT_W'(1)) begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (i_clk_en) begin
			cnt_ff <= nxt_cnt;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
		end
	end

	assign o_busy = busy_ff;
	assign o_done = done_ff;
endmodule // onhook_timer

// >>> test_line_interface_control.sv
module test_line_interface_control
	import lic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk, reset_n, clk_en, rd, wr, offhook_req, sample_tick;
	logic [7:0] address;
	logic [3:0] byteenable;
	logic [31:0] writedata, readdata, rdat;
	logic waitrequest, offhook, onhook_busy;
	line_ctrl_s line_ctrl;
	int num_errors, checked;
	// short release counts keep the run brief
	line_interface_control #(.FAST_TICKS(8), .SLOW_TICKS(16))
		i_line_interface_control (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
		.i_clk_en(clk_en), .i_address(address), .i_read(rd), .i_write(wr),
		.i_byteenable(byteenable), .i_writedata(writedata),
		.o_readdata(readdata), .o_waitrequest(waitrequest),
		.i_offhook_req(offhook_req), .i_sample_tick(sample_tick),
		.o_offhook(offhook), .o_onhook_busy(onhook_busy),
		.o_line_ctrl(line_ctrl));
	// 40 mhz clock
	always #12.5 ref_clk = ~ref_clk;
	// expected decode; bit 7 meaning hangs on hook state
	function automatic line_ctrl_s exp_ctrl(logic [7:0] r, logic off);
		return {off & r[7], ~off & r[7], r[5], r[3:2], r[1], r[0]};
	endfunction
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_ctrl(input line_ctrl_s got, input line_ctrl_s exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one avalon transfer; request held until waitrequest seen low
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		rd <= ~w;
		wr <= w;
		address <= a;
		writedata <= d;
		// only the watchdog ends a wait that never completes
		do
			@(posedge ref_clk);
		while (waitrequest !== 1'b0);
		q = readdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic t_reset();
		bus(1'b0, 8'h10, 32'h0, rdat);
		cmp_word(rdat, {24'h0, LIC_RESET});
		cmp_ctrl(line_ctrl, exp_ctrl(8'h08, 1'b0));
	endtask
	// every dc mode, both ac, ringer and threshold values, bit 4 dropped
	task automatic t_fields();
		logic [7:0] vals [4] = '{8'hff, 8'h00, 8'ha6, 8'h59};
		foreach (vals[i]) begin
			bus(1'b1, 8'h10, {24'hffffff, vals[i]}, rdat);
			bus(1'b0, 8'h10, 32'h0, rdat);
			cmp_word(rdat, {24'h0, vals[i] & 8'hef});
			cmp_ctrl(line_ctrl, exp_ctrl(vals[i], 1'b0));
		end
	endtask
	// unmapped place and disabled lane leave the register alone
	task automatic t_unmapped();
		bus(1'b1, 8'h14, 32'h55, rdat);
		bus(1'b0, 8'h14, 32'h0, rdat);
		cmp_word(rdat, 32'h0);
		byteenable <= 4'h0;
		bus(1'b1, 8'h10, 32'h22, rdat);
		byteenable <= 4'hf;
		bus(1'b0, 8'h10, 32'h0, rdat);
		cmp_word(rdat, 32'h49);
		// enable low: a pending write is neither answered nor stored
		clk_en <= 1'b0;
		wr <= 1'b1;
		address <= 8'h10;
		writedata <= 32'h0;
		repeat (3) @(posedge ref_clk);
		cmp_word({31'h0, waitrequest}, 32'h1);
		cmp_ctrl(line_ctrl, exp_ctrl(8'h49, 1'b0));
		wr <= 1'b0;
		clk_en <= 1'b1;
		@(posedge ref_clk);
		bus(1'b0, 8'h10, 32'h0, rdat);
		cmp_word(rdat, 32'h49);
	endtask
	// go off-hook, release, count sample ticks until the hook drops
	task automatic t_hook(input logic slow, input logic [31:0] ticks);
		logic [31:0] n;
		bus(1'b1, 8'h10, {24'h0, 1'b1, slow, 6'h2b}, rdat);
		offhook_req <= 1'b1;
		repeat (4) @(posedge ref_clk);
		cmp_word({31'h0, offhook}, 32'h1);
		cmp_ctrl(line_ctrl, exp_ctrl({1'b1, slow, 6'h2b}, 1'b1));
		offhook_req <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cmp_word({31'h0, onhook_busy}, 32'h1);
		n = 0;
		repeat (40) begin
			if (offhook === 1'b1) begin
				sample_tick <= 1'b1;
				@(posedge ref_clk);
				sample_tick <= 1'b0;
				repeat (4) @(posedge ref_clk);
				n++;
			end
		end
		cmp_word(n, ticks);
		cmp_word({31'h0, onhook_busy}, 32'h0);
		cmp_ctrl(line_ctrl, exp_ctrl({1'b1, slow, 6'h2b}, 1'b0));
	endtask
	task automatic final_report();
		if (num_errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence after three reset cycles
	initial begin
		{ref_clk, reset_n, rd, wr, offhook_req, sample_tick} = 6'h0;
		{clk_en, byteenable, address, writedata} = {1'b1, 4'hf, 40'h0};
		num_errors = 0;
		checked = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		t_reset();
		t_fields();
		t_unmapped();
		t_hook(1'b0, 32'd8);
		t_hook(1'b1, 32'd16);
		final_report();
	end
	// watchdog against a hung handshake
	initial begin
		#500000;
		num_errors++;
		final_report();
	end
endmodule // test_line_interface_control
